// >>> logic/fbt_fault_balance.sv
`timescale 1ns/1ps
// Overview of operation
// R1: with crc mask set, crc error sets its status bit but not fault pin
// R2: latched error flags stay set until the host clears them
// R3: host writing 1 to a latched status bit clears only that bit
// R4: status bits ignore ordinary writes except write-one-to-clear
// R5: both injected-test bits are written directly, 0 clears them
// R6: injected-test bits assert south pin, base device asserts host pin
// R7: balance outputs follow balance bits while the safety timer runs
// R8: timer expiry clears all balance outputs
// R9: bit 7 selects seconds (0) or minutes (1) for the safety period
// R10: timer restarts full period when balance bits go zero to non-zero
// R11: timer resets when bits are cleared or period expires
// R12: non-zero to non-zero changes do not restart the timer
// R13: bit changes reach outputs at once while timer runs
// R14: period rewritable any time; zero period forbids balancing
// R15: timer-running status bit reads 1 while counting
// R16: aux output switched by its io control enable bit
// R17: external regulator off in sleep mode
// R18: persistent low supply stops balancing and faults, clears balance, sets lockout
// R19: persistent supply at reset level disables the whole device
// R20: leaving reset loads defaults, sets por bit, clears address state
// R21: reset code write resets like power-on but with short period
// R22: reset command accepted whatever address is held
// R23: north fault input passes to south fault output
// R24: chain pins are active high
// R25: timer ticks once per second, minutes are sixty ticks
// R26: base-select picks host pins, others drive only south pins
module fbt_fault_balance import fbt_pkg::*; #(
  parameter int TICKS     = TICK_CYC,
  parameter int LOCK_CYC  = LOCK_DLY_CYC,
  parameter int SRST_CYC  = SOFT_RST_CYC
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // register access from the packet layer
  input  wire fbt_wr_s    i_reg_wr,
  input  wire logic [7:0] i_rd_addr,
  output logic [7:0]      o_rd_data,
  // detector events and supply comparators
  input  wire logic [5:0] i_fault_evt,
  input  wire logic [7:0] i_alert_evt,
  input  wire logic       i_supply_low,
  input  wire logic       i_supply_por,
  // fault and alert chain
  input  wire logic       i_base_sel,
  input  wire fbt_chain_s i_north,
  output fbt_chain_s      o_south,
  output fbt_chain_s      o_host,
  // outputs to the analog side
  output logic [5:0]      o_balance_output,
  output logic            o_aux_en,
  output logic            o_external_regulator_en,
  output logic            o_device_en,
  output logic            o_address_valid_flag
);

  typedef struct packed {
    logic [5:0]       fault_st;
    logic [7:0]       alert_st;
    logic             dev_lock;
    logic [7:0]       io_ctrl;
    logic [7:0]       io_cfg;
    logic [7:0]       balance_control;
    logic [7:0]       balance_safety_period;
    logic [7:0]       addr_ctrl;
    logic             address_valid_flag;
    logic [7:0]       rd_data;
    logic [CNT_W-1:0] lock_cnt;
    logic [CNT_W-1:0] por_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic             prev_nz;
    fbt_chain_s       south;
    fbt_chain_s       host;
    logic [5:0]       bal_out;
  } fbt_state_s;

  fbt_state_s st_q;
  fbt_state_s st_d;
  logic       wr_ok;
  logic       lock_act;
  logic       por_act;
  logic       tmr_start;
  logic       tmr_stop;
  logic       tmr_run;
  logic       tmr_expire;
  logic       fault_any;
  logic       alert_any;
  logic [5:0] fault_w1c;
  logic [7:0] alert_w1c;
  logic [5:0] fault_ev;
  logic [7:0] alert_ev;

  // one decode used by every register write except the reset code
  function automatic logic hit(input fbt_wr_s w, input logic [7:0] a);
    return w.en && (w.addr == a);
  endfunction

  // ==========================================================
  // safety timer
  fbt_safety_timer #(
    .TICKS (TICKS)
  ) u_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_start   (tmr_start),
    .i_stop    (tmr_stop),
    .i_period  (st_q.balance_safety_period),
    .i_minutes (st_q.balance_control[BAL_MINUTES]),  // [R9]
    .o_running (tmr_run),
    .o_expire  (tmr_expire)
  );

  // ==========================================================
  // next state
  always_comb begin
    st_d      = st_q;
    lock_act  = st_q.lock_cnt == CNT_W'(LOCK_CYC);
    por_act   = st_q.por_cnt == CNT_W'(LOCK_CYC);
    wr_ok     = i_reg_wr.en && st_q.hold_cnt == '0 && !por_act;
    // detectors are muted during lockout
    fault_ev  = lock_act ? 6'h00 : (i_fault_evt & ~(FAULT_POR_M | FAULT_FORCE_M));
    alert_ev  = lock_act ? 8'h00 : (i_alert_evt & ~ALERT_FORCE_M);
    fault_w1c = (wr_ok && hit(i_reg_wr, A_FAULT_STATUS)) ? i_reg_wr.data[5:0] : 6'h00;
    alert_w1c = (wr_ok && hit(i_reg_wr, A_ALERT_STATUS)) ? i_reg_wr.data : 8'h00;
    tmr_start = (|st_q.balance_control[5:0]) && !st_q.prev_nz;        // [R10] [R12]
    tmr_stop  = !(|st_q.balance_control[5:0]) || lock_act
                || st_q.balance_safety_period == 8'h00;               // [R11] [R14]
    // persistence counters for the two supply comparators
    st_d.lock_cnt = !i_supply_low ? '0 : (lock_act ? st_q.lock_cnt : st_q.lock_cnt + 1'b1);
    st_d.por_cnt  = !i_supply_por ? '0 : (por_act ? st_q.por_cnt : st_q.por_cnt + 1'b1);
    st_d.hold_cnt = st_q.hold_cnt == '0 ? '0 : st_q.hold_cnt - 1'b1;
    st_d.prev_nz  = |st_q.balance_control[5:0];
    // sticky flags: an event in the clearing cycle wins
    st_d.fault_st = (st_q.fault_st & ~(fault_w1c & ~FAULT_FORCE_M)) | fault_ev;   // [R2] [R3] [R4]
    st_d.alert_st = (st_q.alert_st & ~(alert_w1c & ~ALERT_FORCE_M)) | alert_ev;   // [R2] [R3] [R4]
    if (wr_ok && hit(i_reg_wr, A_FAULT_STATUS)) begin
      st_d.fault_st[F_FORCE] = i_reg_wr.data[F_FORCE];                 // [R5]
    end
    if (wr_ok && hit(i_reg_wr, A_ALERT_STATUS)) begin
      st_d.alert_st[A_FORCE] = i_reg_wr.data[A_FORCE];                 // [R5]
    end
    if (wr_ok && hit(i_reg_wr, A_DEV_STATUS) && i_reg_wr.data[DEV_LOCKOUT]) begin
      st_d.dev_lock = 1'b0;
    end
    if (wr_ok && hit(i_reg_wr, A_IO_CONTROL)) begin
      st_d.io_ctrl = i_reg_wr.data;
    end
    if (wr_ok && hit(i_reg_wr, A_IO_CONFIG)) begin
      st_d.io_cfg = i_reg_wr.data;
    end
    if (wr_ok && hit(i_reg_wr, A_BAL_CTRL)) begin
      st_d.balance_control = i_reg_wr.data;
    end
    if (wr_ok && hit(i_reg_wr, A_BAL_PERIOD)) begin
      st_d.balance_safety_period = i_reg_wr.data;                      // [R14]
    end
    if (wr_ok && hit(i_reg_wr, A_ADDR_CTRL)) begin
      st_d.addr_ctrl          = i_reg_wr.data;
      st_d.address_valid_flag = i_reg_wr.data >= ADDR_MIN && i_reg_wr.data <= ADDR_MAX;
    end
    // lockout: balancing dropped, flag latched until host clears it
    if (lock_act) begin
      st_d.balance_control = REG_RST;                                  // [R18]
      st_d.dev_lock        = 1'b1;                                     // [R18]
    end
    // pins: crc errors may be kept off the fault chain
    fault_any = |(st_q.fault_st & ~(st_q.io_cfg[CFG_CRC_MASK] ? FAULT_CRC_M : 6'h00)); // [R1]
    alert_any = |st_q.alert_st;
    st_d.south.fault = !i_base_sel && (fault_any || i_north.fault);    // [R6] [R23] [R24] [R26]
    st_d.south.alert = !i_base_sel && (alert_any || i_north.alert);    // [R6] [R24] [R26]
    st_d.host.fault  = i_base_sel && (fault_any || i_north.fault);     // [R6] [R26]
    st_d.host.alert  = i_base_sel && (alert_any || i_north.alert);     // [R6] [R26]
    // outputs follow the bits only while the timer counts
    st_d.bal_out = (tmr_run && !tmr_stop && !tmr_expire) ?
                   st_q.balance_control[5:0] : 6'h00;                  // [R7] [R8] [R13]
    // read mux; unmapped reads return zero
    case (i_rd_addr)
      A_DEV_STATUS:   st_d.rd_data = {4'h0, tmr_run, st_q.dev_lock,
                                      alert_any, fault_any};           // [R15]
      A_FAULT_STATUS: st_d.rd_data = {2'b00, st_q.fault_st};
      A_ALERT_STATUS: st_d.rd_data = st_q.alert_st;
      A_IO_CONTROL:   st_d.rd_data = st_q.io_ctrl;
      A_IO_CONFIG:    st_d.rd_data = st_q.io_cfg;
      A_BAL_CTRL:     st_d.rd_data = st_q.balance_control;
      A_BAL_PERIOD:   st_d.rd_data = st_q.balance_safety_period;
      A_ADDR_CTRL:    st_d.rd_data = st_q.addr_ctrl;
      default:        st_d.rd_data = 8'h00;
    endcase
    // reset code is honoured even without a valid address or via broadcast
    if (i_reg_wr.en && i_reg_wr.addr == A_RESET && i_reg_wr.data == RESET_CODE) begin
      st_d.hold_cnt = CNT_W'(SRST_CYC);                                // [R21] [R22]
    end
    // held in reset: defaults loaded, por flag set, address forgotten
    if (por_act || st_q.hold_cnt != '0) begin                          // [R19] [R20]
      st_d.fault_st              = FAULT_POR_M;
      st_d.alert_st              = REG_RST;
      st_d.dev_lock              = 1'b0;
      st_d.io_ctrl               = REG_RST;
      st_d.io_cfg                = REG_RST;
      st_d.balance_control       = REG_RST;
      st_d.balance_safety_period = REG_RST;
      st_d.addr_ctrl             = REG_RST;
      st_d.address_valid_flag    = 1'b0;
      st_d.rd_data               = REG_RST;
      st_d.south                 = '0;
      st_d.host                  = '0;
      st_d.bal_out               = 6'h00;
    end
  end

  // ==========================================================
  // state register; power-on leaves the por flag latched
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q          <= '0;
      st_q.fault_st <= FAULT_POR_M;                                    // [R20]
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_rd_data               = st_q.rd_data;
  assign o_south                 = st_q.south;
  assign o_host                  = st_q.host;
  assign o_balance_output        = st_q.bal_out;
  assign o_external_regulator_en = !st_q.io_ctrl[IO_SLEEP];                        // [R17]
  assign o_aux_en                = st_q.io_ctrl[IO_AUX] && !st_q.io_ctrl[IO_SLEEP]; // [R16]
  assign o_device_en             = !por_act;                                       // [R19]
  assign o_address_valid_flag    = st_q.address_valid_flag;

  // ==========================================================
  // checks
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_crc_masked;
    st_q.io_cfg[CFG_CRC_MASK] && st_q.fault_st == FAULT_CRC_M && !i_north.fault
      |=> !o_south.fault && !o_host.fault;
  endproperty
  a_crc_masked: assert property (p_crc_masked) else $error("masked crc drove fault pin"); // [R1]

  property p_latched;
    st_q.fault_st[F_CRC] && !i_reg_wr.en && !por_act && st_q.hold_cnt == '0
      |=> st_q.fault_st[F_CRC];
  endproperty
  a_latched: assert property (p_latched) else $error("latched flag dropped by itself"); // [R2]

  property p_w1c;
    wr_ok && hit(i_reg_wr, A_FAULT_STATUS) && i_reg_wr.data[F_CRC] && !i_fault_evt[F_CRC]
      |=> !st_q.fault_st[F_CRC];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear"); // [R3]

  property p_w0_keeps;
    wr_ok && hit(i_reg_wr, A_ALERT_STATUS) && i_reg_wr.data == 8'h00 && st_q.alert_st[0]
      |=> st_q.alert_st[0];
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("write zero cleared a flag"); // [R4]

  property p_force_direct;
    wr_ok && hit(i_reg_wr, A_FAULT_STATUS)
      |=> st_q.fault_st[F_FORCE] == $past(i_reg_wr.data[F_FORCE]);
  endproperty
  a_force_direct: assert property (p_force_direct) else $error("force bit not written"); // [R5]

  property p_force_host;
    i_base_sel && st_q.fault_st[F_FORCE] && !por_act && st_q.hold_cnt == '0 |=> o_host.fault;
  endproperty
  a_force_host: assert property (p_force_host) else $error("force did not reach host pin"); // [R6]

  property p_bal_idle;
    !tmr_run |=> o_balance_output == 6'h00;
  endproperty
  a_bal_idle: assert property (p_bal_idle) else $error("balance on without timer"); // [R8]

  property p_bal_follow;
    tmr_run && !tmr_stop && !tmr_expire && !por_act && st_q.hold_cnt == '0
      |=> o_balance_output == $past(st_q.balance_control[5:0]);
  endproperty
  a_bal_follow: assert property (p_bal_follow) else $error("balance output not following"); // [R7]

  property p_start;
    tmr_start && !tmr_stop |=> tmr_run ##1 o_balance_output != 6'h00 || tmr_stop;
  endproperty
  a_start: assert property (p_start) else $error("timer did not start"); // [R10]

  property p_lockout;
    lock_act && !por_act && st_q.hold_cnt == '0 |=> st_q.balance_control == 8'h00 && st_q.dev_lock;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout left balance set"); // [R18]

  property p_soft_reset;
    i_reg_wr.en && i_reg_wr.addr == A_RESET && i_reg_wr.data == RESET_CODE
      |=> ##1 st_q.fault_st == FAULT_POR_M && !st_q.address_valid_flag;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("reset code ignored"); // [R21]

  property p_cbt_read;
    i_rd_addr == A_DEV_STATUS && !por_act && st_q.hold_cnt == '0
      |=> o_rd_data[DEV_TIMER_RUN] == $past(tmr_run);
  endproperty
  a_cbt_read: assert property (p_cbt_read) else $error("timer status bit wrong"); // [R15]

  c_expire:  cover property (tmr_expire);
  c_restart: cover property (tmr_run && tmr_start);
  c_lockout: cover property (lock_act ##1 st_q.dev_lock);
  c_soft:    cover property (st_q.hold_cnt == CNT_W'(1));

endmodule

// >>> logic/fbt_pkg.sv
package fbt_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int TICK_S        = 1;                     // safety timer tick, seconds
  localparam int TICK_CYC      = CLK_HZ * TICK_S;
  localparam int MIN_TICKS     = 60;                    // ticks per count in minute range
  localparam int SOFT_RST_US   = 300;                   // shortened reset period
  localparam int SOFT_RST_CYC  = SOFT_RST_US * (CLK_HZ / 1_000_000);
  localparam int LOCK_DLY_US   = 100;                   // lockout persistence delay
  localparam int LOCK_DLY_CYC  = LOCK_DLY_US * (CLK_HZ / 1_000_000);
  localparam int TICK_W        = 26;
  localparam int SUB_W         = 6;
  localparam int CNT_W         = 16;

  // ==========================================================
  // register indices
  localparam logic [7:0] A_DEV_STATUS   = 8'h00;
  localparam logic [7:0] A_FAULT_STATUS = 8'h01;
  localparam logic [7:0] A_ALERT_STATUS = 8'h02;
  localparam logic [7:0] A_IO_CONTROL   = 8'h03;
  localparam logic [7:0] A_IO_CONFIG    = 8'h04;
  localparam logic [7:0] A_BAL_CTRL     = 8'h05;
  localparam logic [7:0] A_BAL_PERIOD   = 8'h06;
  localparam logic [7:0] A_ADDR_CTRL    = 8'h07;
  localparam logic [7:0] A_RESET        = 8'h08;
  localparam logic [7:0] RESET_CODE     = 8'ha5;
  localparam logic [7:0] ADDR_MIN       = 8'h01;
  localparam logic [7:0] ADDR_MAX       = 8'h3e;

  // ==========================================================
  // field layouts
  localparam int DEV_FAULT      = 0;
  localparam int DEV_ALERT      = 1;
  localparam int DEV_LOCKOUT    = 2;
  localparam int DEV_TIMER_RUN  = 3;
  localparam int F_CRC          = 2;
  localparam int F_POR          = 4;
  localparam int F_FORCE        = 5;
  localparam int A_FORCE        = 4;
  localparam int IO_AUX         = 0;
  localparam int IO_SLEEP       = 2;
  localparam int CFG_CRC_MASK   = 7;
  localparam int BAL_MINUTES    = 7;
  localparam logic [5:0] FAULT_CRC_M   = 6'h04;
  localparam logic [5:0] FAULT_POR_M   = 6'h10;
  localparam logic [5:0] FAULT_FORCE_M = 6'h20;
  localparam logic [7:0] ALERT_FORCE_M = 8'h10;
  localparam logic [7:0] DEV_LOCK_M    = 8'h04;

  // ==========================================================
  // reset values
  localparam logic [7:0] REG_RST = 8'h00;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       en;
    logic       bcast;
    logic [7:0] addr;
    logic [7:0] data;
  } fbt_wr_s;

  typedef struct packed {
    logic fault;
    logic alert;
  } fbt_chain_s;

endpackage

// >>> logic/fbt_safety_timer.sv
`timescale 1ns/1ps
module fbt_safety_timer import fbt_pkg::*; #(
  parameter int TICKS = TICK_CYC
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // control
  input  wire logic       i_start,
  input  wire logic       i_stop,
  input  wire logic [7:0] i_period,
  input  wire logic       i_minutes,
  // status
  output logic            o_running,
  output logic            o_expire
);

  typedef struct packed {
    logic              running;
    logic [TICK_W-1:0] tick;
    logic [SUB_W-1:0]  sub;
    logic [7:0]        remain;
  } fbt_tmr_s;

  fbt_tmr_s st_q;
  fbt_tmr_s st_d;
  logic     tick_done;
  logic     count_done;

  // ==========================================================
  // countdown: one-second ticks, sixty of them per count in minute range
  always_comb begin
    st_d       = st_q;
    tick_done  = st_q.tick == TICK_W'(TICKS - 1);
    count_done = tick_done && (!i_minutes || st_q.sub == SUB_W'(MIN_TICKS - 1));
    o_expire   = 1'b0;
    if (i_stop) begin
      st_d.running = 1'b0;                               // [R11]
    end else if (i_start) begin
      st_d.running = i_period != 8'h00;                  // [R10] [R14]
      st_d.remain  = i_period;
      st_d.tick    = '0;
      st_d.sub     = '0;
    end else if (st_q.running) begin
      st_d.tick = tick_done ? '0 : st_q.tick + 1'b1;     // [R25]
      if (tick_done) begin
        st_d.sub = count_done ? '0 : st_q.sub + 1'b1;
      end
      if (count_done) begin
        st_d.remain = st_q.remain - 1'b1;
        if (st_q.remain <= 8'h01) begin
          st_d.running = 1'b0;                           // [R8] [R11]
          o_expire     = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_running = st_q.running;

endmodule

// >>> test/fbt_fault_balance_bench.sv
`timescale 1ns/1ps
module fbt_fault_balance_bench import fbt_pkg::*; ;
  // ==========================================================
  // bench signals
  localparam int LK = 4;
  localparam int SR = 8;
  logic       ref_clk   = 1'b0;
  logic       rst       = 1'b1;
  fbt_wr_s    wr        = '0;
  logic [7:0] rd_addr   = 8'h00;
  logic [5:0] fault_evt = 6'h00;
  logic [7:0] alert_evt = 8'h00;
  logic       sup_low   = 1'b0;
  logic       sup_por   = 1'b0;
  logic       base_sel  = 1'b0;
  logic       peer_f    = 1'b0;
  logic [7:0] rd_data;
  fbt_chain_s north;
  fbt_chain_s south;
  fbt_chain_s host;
  logic [5:0] bal;
  logic       aux;
  logic       ext_reg;
  logic       dev_en;
  logic       addr_ok;
  int         miscompares = 0;
  int         n_compared  = 0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  fbt_north_peer u_fbt_north_peer (.i_ref_clk(ref_clk), .i_rst(rst), .i_fault(peer_f),
    .i_alert(1'b0), .o_south(north));
  // short counts keep the timer and hold periods within a quick run
  fbt_fault_balance #(.TICKS(10), .LOCK_CYC(LK), .SRST_CYC(SR)) u_fbt_fault_balance (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_reg_wr(wr), .i_rd_addr(rd_addr),
    .o_rd_data(rd_data), .i_fault_evt(fault_evt), .i_alert_evt(alert_evt),
    .i_supply_low(sup_low), .i_supply_por(sup_por), .i_base_sel(base_sel),
    .i_north(north), .o_south(south), .o_host(host), .o_balance_output(bal),
    .o_aux_en(aux), .o_external_regulator_en(ext_reg), .o_device_en(dev_en),
    .o_address_valid_flag(addr_ok));

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // strobe drops and a full cycle passes, so back-to-back calls never overlap
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr <= '{1'b1, 1'b0, a, d};
    cyc(1);
    wr.en <= 1'b0;
    cyc(1);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    rd_addr <= a;
    cyc(1);
    check(what, rd_data, exp);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_status();
    rd_chk("fault after reset", A_FAULT_STATUS, 8'h10);
    check("addr valid", 8'(addr_ok), 8'h00);
    wr_reg(A_FAULT_STATUS, 8'h0f);
    rd_chk("fault ro write", A_FAULT_STATUS, 8'h10);
    wr_reg(A_FAULT_STATUS, 8'h10);
    rd_chk("fault w1c", A_FAULT_STATUS, 8'h00);
    alert_evt <= 8'h01;
    cyc(1);
    alert_evt <= 8'h00;
    cyc(3);
    rd_chk("alert latched", A_ALERT_STATUS, 8'h01);
    wr_reg(A_ALERT_STATUS, 8'h02);
    rd_chk("alert other bit", A_ALERT_STATUS, 8'h01);
    wr_reg(A_ALERT_STATUS, 8'h01);
    rd_chk("alert w1c", A_ALERT_STATUS, 8'h00);
    $display("status test done");
  endtask
  task automatic t_force();
    for (int i = 0; i < 2; i++) begin
      logic [7:0] m;
      m = (i == 1) ? ALERT_FORCE_M : {2'b00, FAULT_FORCE_M};
      base_sel <= 1'b0;
      wr_reg(A_FAULT_STATUS + 8'(i), m);
      rd_chk("force set", A_FAULT_STATUS + 8'(i), m);
      cyc(2);
      check("south pin", 8'(south[1-i]), 8'h01);
      check("host pin off", 8'(host[1-i]), 8'h00);
      base_sel <= 1'b1;
      cyc(3);
      check("host pin", 8'(host[1-i]), 8'h01);
      wr_reg(A_FAULT_STATUS + 8'(i), 8'h00);
      rd_chk("force clear", A_FAULT_STATUS + 8'(i), 8'h00);
    end
    peer_f <= 1'b1;
    cyc(4);
    check("north to host", 8'(host.fault), 8'h01);
    peer_f <= 1'b0;
    cyc(4);
    check("north released", 8'(host.fault), 8'h00);
    $display("chain test done");
  endtask
  task automatic t_crc();
    for (int i = 0; i < 2; i++) begin
      wr_reg(A_IO_CONFIG, (i == 0) ? 8'h80 : 8'h00);
      fault_evt <= FAULT_CRC_M;
      cyc(1);
      fault_evt <= 6'h00;
      cyc(3);
      rd_chk("crc status", A_FAULT_STATUS, 8'h04);
      check("crc pin", 8'(host.fault), 8'(i));
      wr_reg(A_FAULT_STATUS, 8'h04);
    end
    $display("crc test done");
  endtask
  task automatic t_balance();
    wr_reg(A_BAL_PERIOD, 8'h03);
    wr_reg(A_BAL_CTRL, 8'h03);
    cyc(2);
    check("balance on", 8'(bal), 8'h03);
    rd_chk("timer running", A_DEV_STATUS, 8'h08);
    wr_reg(A_BAL_CTRL, 8'h02);
    cyc(2);
    check("balance follow", 8'(bal), 8'h02);
    cyc(19);
    check("balance before expiry", 8'(bal), 8'h02);
    cyc(7);
    check("balance expired", 8'(bal), 8'h00);
    rd_chk("timer stopped", A_DEV_STATUS, 8'h00);
    wr_reg(A_BAL_CTRL, 8'h00);
    wr_reg(A_BAL_PERIOD, 8'h01);
    wr_reg(A_BAL_CTRL, 8'h81);
    cyc(2);
    check("minutes restart", 8'(bal), 8'h01);
    cyc(300);
    check("minutes running", 8'(bal), 8'h01);
    cyc(320);
    check("minutes expired", 8'(bal), 8'h00);
    wr_reg(A_BAL_CTRL, 8'h00);
    wr_reg(A_BAL_CTRL, 8'h04);
    cyc(2);
    check("restart", 8'(bal), 8'h04);
    wr_reg(A_BAL_CTRL, 8'h00);
    cyc(2);
    check("host clear", 8'(bal), 8'h00);
    rd_chk("timer reset", A_DEV_STATUS, 8'h00);
    wr_reg(A_BAL_PERIOD, 8'h00);
    wr_reg(A_BAL_CTRL, 8'h3f);
    cyc(3);
    check("zero period", 8'(bal), 8'h00);
    wr_reg(A_BAL_CTRL, 8'h00);
    $display("balance test done");
  endtask
  task automatic t_power();
    wr_reg(A_IO_CONTROL, 8'h01);
    check("aux on", 8'(aux), 8'h01);
    wr_reg(A_IO_CONTROL, 8'h04);
    check("regulator sleep", 8'(ext_reg), 8'h00);
    wr_reg(A_IO_CONTROL, 8'h00);
    check("regulator awake", 8'(ext_reg), 8'h01);
    wr_reg(A_BAL_PERIOD, 8'h05);
    wr_reg(A_BAL_CTRL, 8'h3f);
    sup_low <= 1'b1;
    cyc(LK + 4);
    check("lockout balance", 8'(bal), 8'h00);
    rd_chk("lockout ctrl", A_BAL_CTRL, 8'h00);
    rd_chk("lockout bit", A_DEV_STATUS, DEV_LOCK_M);
    sup_low <= 1'b0;
    // let the persistence counter drop first, or the lockout sets the flag again
    cyc(1);
    wr_reg(A_DEV_STATUS, DEV_LOCK_M);
    rd_chk("lockout cleared", A_DEV_STATUS, 8'h00);
    wr_reg(A_ADDR_CTRL, 8'h05);
    check("addr set", 8'(addr_ok), 8'h01);
    wr_reg(A_RESET, RESET_CODE);
    cyc(SR + 4);
    check("soft reset addr", 8'(addr_ok), 8'h00);
    rd_chk("soft reset por", A_FAULT_STATUS, 8'h10);
    rd_chk("soft reset addr ctrl", A_ADDR_CTRL, 8'h00);
    sup_por <= 1'b1;
    cyc(LK + 4);
    check("device off", 8'(dev_en), 8'h00);
    sup_por <= 1'b0;
    cyc(SR + LK + 4);
    check("device back", 8'(dev_en), 8'h01);
    $display("power test done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    cyc(10);
    rst <= 1'b0;
    cyc(1);
    t_status();
    t_force();
    t_crc();
    t_balance();
    t_power();
    give_verdict();
  end
  // the whole run needs under 1500 cycles, so this only fires on a hang
  initial begin
    cyc(5000);
    miscompares++;
    give_verdict();
  end
endmodule

// >>> test/fbt_north_peer.sv
`timescale 1ns/1ps
module fbt_north_peer import fbt_pkg::*; (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // requests from the bench
  input  wire logic i_fault,
  input  wire logic i_alert,
  // south pins of the upper neighbour
  output fbt_chain_s o_south
);
  // ==========================================================
  // upper neighbour chain pins
  // registered like a real neighbour, so the pins move one clock after a request
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_south <= '0;
    end else begin
      o_south <= '{fault: i_fault, alert: i_alert};
    end
  end
endmodule
